// ### logic/e8alu_consts.svh
`ifndef E8ALU_CONSTS_SVH
`define E8ALU_CONSTS_SVH

// ************************************************************
// flag positions inside the flag vector {H,S,V,N,Z,C}
// ************************************************************
`define E8ALU_FLAG_C 0
`define E8ALU_FLAG_Z 1
`define E8ALU_FLAG_N 2
`define E8ALU_FLAG_V 3
`define E8ALU_FLAG_S 4
`define E8ALU_FLAG_H 5

// ************************************************************
// flag update masks
// ************************************************************
`define E8ALU_MASK_ARITH 6'h3F
`define E8ALU_MASK_WORD  6'h1F
`define E8ALU_MASK_LOGIC 6'h1E
`define E8ALU_MASK_COM   6'h1F
`define E8ALU_MASK_MUL   6'h03
`define E8ALU_MASK_NONE  6'h00

// ************************************************************
// cycle counts
// ************************************************************
`define E8ALU_CYC_ONE   2'h1
`define E8ALU_CYC_TWO   2'h2
`define E8ALU_CYC_THREE 2'h3

// ************************************************************
// reset values and constants
// ************************************************************
`define E8ALU_ALL_ONES 8'hFF
`define E8ALU_RST_PC   22'h000000

`endif

// ### logic/e8alu_pkg.sv
package e8alu_pkg;

  typedef enum logic [4:0] {
    E8ALU_ADD      = 5'h00,
    E8ALU_ADC      = 5'h01,
    E8ALU_SUB      = 5'h02,
    E8ALU_SBC      = 5'h03,
    E8ALU_WADD     = 5'h04,
    E8ALU_WSUB     = 5'h05,
    E8ALU_AND      = 5'h06,
    E8ALU_OR       = 5'h07,
    E8ALU_XOR      = 5'h08,
    E8ALU_SETB     = 5'h09,
    E8ALU_CLRB     = 5'h0A,
    E8ALU_PROBE    = 5'h0B,
    E8ALU_COM      = 5'h0C,
    E8ALU_NEG      = 5'h0D,
    E8ALU_INC      = 5'h0E,
    E8ALU_DEC      = 5'h0F,
    E8ALU_ZREG     = 5'h10,
    E8ALU_ONES     = 5'h11,
    E8ALU_MUL_UU   = 5'h12,
    E8ALU_MUL_SS   = 5'h13,
    E8ALU_MUL_SU   = 5'h14,
    E8ALU_FRACTION_PRODUCT_UNSIGNED_UU  = 5'h15,
    E8ALU_FRACTION_PRODUCT_UNSIGNED_SS  = 5'h16,
    E8ALU_FRACTION_PRODUCT_UNSIGNED_SU  = 5'h17,
    E8ALU_RGOTO    = 5'h18,
    E8ALU_AGOTO    = 5'h19,
    E8ALU_PGOTO    = 5'h1A,
    E8ALU_RELATIVE_SUBROUTINE_ENTRY    = 5'h1B,
    E8ALU_PCALL    = 5'h1C
  } e8alu_op_t;

  typedef enum logic [1:0] {
    E8ALU_IDLE = 2'b00,
    E8ALU_BUSY = 2'b01,
    E8ALU_LAST = 2'b11
  } e8alu_state_t;

  typedef struct packed {
    e8alu_state_t state;
    logic [1:0]   left;
    logic         done;
    logic         wr_en;
    logic         wr_pair;
    logic         wr_fixed;
    logic [15:0]  result;
    logic [5:0]   flag_mask;
    logic [5:0]   flags;
    logic         pc_load;
    logic [21:0]  pc_next;
    logic         push_ret;
  } e8alu_regs_t;

endpackage

// ### logic/e8alu_execute.sv
`timescale 1ns/1ps
`include "e8alu_consts.svh"
// Summary of operation
// - byte add/subtract: write, six flags, one cycle
// - word add immediate: five flags, two cycles
// - word subtract immediate: keep H, two cycles
// - AND: write, Z N V S, one cycle
// - OR and XOR: Z N V S, one cycle
// - set bits: OR mask, one cycle
// - clear bits: AND inverted mask, one cycle
// - probe: AND self, writes operand back, Z N V S, one cycle
// - multiplies to pair 1:0, Z C, two cycles
// - fractional multiplies shift product left once
// - pointer jump: PC low from Z, high cleared
// - pointer call: PC low from Z, two/three cycles
module e8alu_execute (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // request from decode
  input  wire logic                start,
  input  wire e8alu_pkg::e8alu_op_t op,
  input  wire logic [15:0]         opd_a,
  input  wire logic [7:0]          opd_b,
  input  wire logic [15:0]         z_ptr,
  input  wire logic [21:0]         pc_cur,
  input  wire logic [21:0]         jump_arg,
  input  wire logic                long_pc,
  input  wire logic [5:0]          flags_in,
  // answer to register file and status
  output logic                     busy,
  output logic                     done,
  output logic                     wr_en,
  output logic                     wr_pair,
  output logic                     wr_fixed,
  output logic [15:0]              result,
  output logic [5:0]               flag_mask,
  output logic [5:0]               flags_out,
  output logic                     pc_load,
  output logic [21:0]              pc_next,
  output logic                     push_ret
);

  e8alu_pkg::e8alu_regs_t r;
  e8alu_pkg::e8alu_regs_t next_r;

  // ************************************************************
  // flag helpers
  // ************************************************************
  function automatic logic [5:0] byte_flags(input logic [7:0] res, input logic v,
                                            input logic c, input logic h);
    logic n;
    n = res[7];
    byte_flags = {h, n ^ v, v, n, (res == 8'h00), c};
  endfunction

  function automatic logic [5:0] add_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
    logic [8:0] s;
    logic [4:0] hs;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add_flags = byte_flags(s[7:0], (a[7] == b[7]) && (s[7] != a[7]), s[8], hs[4]);
  endfunction

  function automatic logic [5:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
    logic [8:0] s;
    logic [4:0] hs;
    s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    sub_flags = byte_flags(s[7:0], (a[7] != b[7]) && (s[7] != a[7]), s[8], hs[4]);
  endfunction

  logic [15:0] sa;
  logic [15:0] sb;
  logic [31:0] prod;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.wr_en = 1'b0;
    next_r.pc_load = 1'b0;
    next_r.push_ret = 1'b0;
    next_r.flag_mask = `E8ALU_MASK_NONE;
    sa = 16'h0000;
    sb = 16'h0000;
    prod = 32'h00000000;
    case (r.state)
      e8alu_pkg::E8ALU_IDLE: begin
        if (start) begin
          next_r.wr_pair = 1'b0;
          next_r.wr_fixed = 1'b0;
          next_r.wr_en = 1'b1;
          next_r.done = 1'b1;
          next_r.left = `E8ALU_CYC_ONE;
          next_r.flags = flags_in;
          case (op)
            e8alu_pkg::E8ALU_ADD, e8alu_pkg::E8ALU_ADC: begin
              next_r.result = {8'h00, opd_a[7:0] + opd_b
                               + {7'h00, (op == e8alu_pkg::E8ALU_ADC) & flags_in[`E8ALU_FLAG_C]}};
              next_r.flags = add_flags(opd_a[7:0], opd_b,
                               (op == e8alu_pkg::E8ALU_ADC) & flags_in[`E8ALU_FLAG_C]);
              next_r.flag_mask = `E8ALU_MASK_ARITH;
            end
            e8alu_pkg::E8ALU_SUB, e8alu_pkg::E8ALU_SBC: begin
              next_r.result = {8'h00, opd_a[7:0] - opd_b
                               - {7'h00, (op == e8alu_pkg::E8ALU_SBC) & flags_in[`E8ALU_FLAG_C]}};
              next_r.flags = sub_flags(opd_a[7:0], opd_b,
                               (op == e8alu_pkg::E8ALU_SBC) & flags_in[`E8ALU_FLAG_C]);
              next_r.flag_mask = `E8ALU_MASK_ARITH;
            end
            e8alu_pkg::E8ALU_WADD, e8alu_pkg::E8ALU_WSUB: begin
              sa = (op == e8alu_pkg::E8ALU_WADD) ? opd_a + {8'h00, opd_b}
                                                  : opd_a - {8'h00, opd_b};
              next_r.result = sa;
              next_r.wr_pair = 1'b1;
              next_r.flags[`E8ALU_FLAG_Z] = (sa == 16'h0000);
              next_r.flags[`E8ALU_FLAG_N] = sa[15];
              next_r.flags[`E8ALU_FLAG_V] = (op == e8alu_pkg::E8ALU_WADD)
                                            ? (~opd_a[15] & sa[15]) : (opd_a[15] & ~sa[15]);
              next_r.flags[`E8ALU_FLAG_C] = (op == e8alu_pkg::E8ALU_WADD)
                                            ? (opd_a[15] & ~sa[15]) : (~opd_a[15] & sa[15]);
              next_r.flags[`E8ALU_FLAG_S] = next_r.flags[`E8ALU_FLAG_N]
                                            ^ next_r.flags[`E8ALU_FLAG_V];
              next_r.flag_mask = `E8ALU_MASK_WORD;
              next_r.left = `E8ALU_CYC_TWO;
            end
            e8alu_pkg::E8ALU_AND, e8alu_pkg::E8ALU_OR, e8alu_pkg::E8ALU_XOR,
            e8alu_pkg::E8ALU_SETB, e8alu_pkg::E8ALU_CLRB, e8alu_pkg::E8ALU_PROBE,
            e8alu_pkg::E8ALU_ZREG: begin
              case (op)
                e8alu_pkg::E8ALU_AND:   sa[7:0] = opd_a[7:0] & opd_b;
                e8alu_pkg::E8ALU_OR,
                e8alu_pkg::E8ALU_SETB:  sa[7:0] = opd_a[7:0] | opd_b;
                e8alu_pkg::E8ALU_XOR:   sa[7:0] = opd_a[7:0] ^ opd_b;
                e8alu_pkg::E8ALU_CLRB:  sa[7:0] = opd_a[7:0] & (`E8ALU_ALL_ONES - opd_b);
                e8alu_pkg::E8ALU_PROBE: sa[7:0] = opd_a[7:0] & opd_a[7:0];
                default:                sa[7:0] = opd_a[7:0] ^ opd_a[7:0];
              endcase
              next_r.result = {8'h00, sa[7:0]};
              next_r.flags = byte_flags(sa[7:0], 1'b0, flags_in[`E8ALU_FLAG_C],
                                        flags_in[`E8ALU_FLAG_H]);
              next_r.flag_mask = `E8ALU_MASK_LOGIC;
            end
            e8alu_pkg::E8ALU_COM: begin
              next_r.result = {8'h00, `E8ALU_ALL_ONES - opd_a[7:0]};
              next_r.flags = byte_flags(`E8ALU_ALL_ONES - opd_a[7:0], 1'b0, 1'b1,
                                        flags_in[`E8ALU_FLAG_H]);
              next_r.flag_mask = `E8ALU_MASK_COM;
            end
            e8alu_pkg::E8ALU_NEG: begin
              next_r.result = {8'h00, 8'h00 - opd_a[7:0]};
              next_r.flags = sub_flags(8'h00, opd_a[7:0], 1'b0);
              next_r.flag_mask = `E8ALU_MASK_ARITH;
            end
            e8alu_pkg::E8ALU_INC, e8alu_pkg::E8ALU_DEC: begin
              sa[7:0] = (op == e8alu_pkg::E8ALU_INC) ? opd_a[7:0] + 8'h01 : opd_a[7:0] - 8'h01;
              next_r.result = {8'h00, sa[7:0]};
              next_r.flags = byte_flags(sa[7:0], (op == e8alu_pkg::E8ALU_INC)
                                        ? (sa[7:0] == 8'h80) : (sa[7:0] == 8'h7F),
                                        flags_in[`E8ALU_FLAG_C], flags_in[`E8ALU_FLAG_H]);
              next_r.flag_mask = `E8ALU_MASK_LOGIC;
            end
            e8alu_pkg::E8ALU_ONES: begin
              next_r.result = {8'h00, `E8ALU_ALL_ONES};
            end
            e8alu_pkg::E8ALU_MUL_UU, e8alu_pkg::E8ALU_MUL_SS, e8alu_pkg::E8ALU_MUL_SU,
            e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_UU, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SS, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU: begin
              sa = (op == e8alu_pkg::E8ALU_MUL_UU || op == e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_UU)
                   ? {8'h00, opd_a[7:0]} : {{8{opd_a[7]}}, opd_a[7:0]};
              sb = (op == e8alu_pkg::E8ALU_MUL_SS || op == e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SS)
                   ? {{8{opd_b[7]}}, opd_b} : {8'h00, opd_b};
              prod = {16'h0000, sa} * {16'h0000, sb};
              next_r.flags[`E8ALU_FLAG_C] = prod[15];
              if (op == e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_UU || op == e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SS
                  || op == e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU) begin
                next_r.result = {prod[14:0], 1'b0};
              end else begin
                next_r.result = prod[15:0];
              end
              next_r.flags[`E8ALU_FLAG_Z] = (next_r.result == 16'h0000);
              next_r.wr_pair = 1'b1;
              next_r.wr_fixed = 1'b1;
              next_r.flag_mask = `E8ALU_MASK_MUL;
              next_r.left = `E8ALU_CYC_TWO;
            end
            e8alu_pkg::E8ALU_PGOTO, e8alu_pkg::E8ALU_PCALL: begin
              next_r.wr_en = 1'b0;
              next_r.pc_next = {6'h00, z_ptr};
              next_r.push_ret = (op == e8alu_pkg::E8ALU_PCALL);
              next_r.left = (op == e8alu_pkg::E8ALU_PCALL && long_pc)
                            ? `E8ALU_CYC_THREE : `E8ALU_CYC_TWO;
            end
            e8alu_pkg::E8ALU_RGOTO, e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY: begin
              next_r.wr_en = 1'b0;
              next_r.pc_next = pc_cur + jump_arg + 22'h000001;
              next_r.push_ret = (op == e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY);
              next_r.left = (op == e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY && long_pc)
                            ? `E8ALU_CYC_THREE : `E8ALU_CYC_TWO;
            end
            e8alu_pkg::E8ALU_AGOTO: begin
              next_r.wr_en = 1'b0;
              next_r.pc_next = jump_arg;
              next_r.left = `E8ALU_CYC_THREE;
            end
            default: begin
              next_r.wr_en = 1'b0;
            end
          endcase
          // multi-cycle ops stage strobes and mask; outputs show them only with done
          if (next_r.left != `E8ALU_CYC_ONE) begin
            next_r.state = e8alu_pkg::E8ALU_BUSY;
            next_r.left = next_r.left - 2'h1;
            next_r.done = 1'b0;
          end
          next_r.pc_load = (op inside {e8alu_pkg::E8ALU_RGOTO, e8alu_pkg::E8ALU_AGOTO,
                                       e8alu_pkg::E8ALU_PGOTO, e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY,
                                       e8alu_pkg::E8ALU_PCALL});
        end
      end
      e8alu_pkg::E8ALU_BUSY: begin
        // hold the prepared answer until its last cycle
        if (r.left == `E8ALU_CYC_ONE) begin
          next_r.state = e8alu_pkg::E8ALU_IDLE;
          next_r.done = 1'b1;
          next_r.wr_en = r.wr_en;
          next_r.pc_load = r.pc_load;
          next_r.push_ret = r.push_ret;
          next_r.flag_mask = r.flag_mask;
          next_r.left = `E8ALU_CYC_ONE;
        end else begin
          next_r.left = r.left - 2'h1;
          next_r.wr_en = r.wr_en;
          next_r.pc_load = r.pc_load;
          next_r.push_ret = r.push_ret;
          next_r.flag_mask = r.flag_mask;
        end
      end
      default: begin
        next_r.state = e8alu_pkg::E8ALU_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '{state: e8alu_pkg::E8ALU_IDLE, left: `E8ALU_CYC_ONE, pc_next: `E8ALU_RST_PC,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs; in busy cycles the strobes are staged, so gate them
  // ************************************************************
  assign busy      = r.state[0];
  assign done      = r.done;
  assign wr_en     = r.wr_en & r.done;
  assign wr_pair   = r.wr_pair;
  assign wr_fixed  = r.wr_fixed;
  assign result    = r.result;
  assign flag_mask = r.done ? r.flag_mask : 6'h00;
  assign flags_out = r.flags;
  assign pc_load   = r.pc_load & r.done;
  assign pc_next   = r.pc_next;
  assign push_ret  = r.push_ret & r.done;

endmodule

// ### tb/e8alu_execute_sva.sv
`timescale 1ns/1ps
module e8alu_execute_sva (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // request
  input wire logic                 start,
  input wire e8alu_pkg::e8alu_op_t op,
  input wire logic [15:0]          z_ptr,
  input wire logic [21:0]          jump_arg,
  input wire logic                 long_pc,
  // answer
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic                 wr_en,
  input wire logic                 wr_pair,
  input wire logic                 wr_fixed,
  input wire logic [15:0]          result,
  input wire logic [5:0]           flag_mask,
  input wire logic [5:0]           flags_out,
  input wire logic                 pc_load,
  input wire logic [21:0]          pc_next,
  input wire logic                 push_ret
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  byte_answer_a: assert property (start && !busy && op <= e8alu_pkg::E8ALU_SBC
    |=> done && wr_en && !wr_pair && flag_mask == 6'h3F) else $error("byte sum answer wrong");
  zero_flag_a: assert property (done && flag_mask == 6'h3F
    |-> flags_out[1] == (result[7:0] == 8'h00)) else $error("zero flag wrong");
  word_two_a: assert property (start && !busy && op inside {e8alu_pkg::E8ALU_WADD,
    e8alu_pkg::E8ALU_WSUB} |=> !done ##1 done && wr_pair && flag_mask == 6'h1F)
    else $error("word op timing or mask wrong");
  logic_mask_a: assert property (start && !busy && op inside {[e8alu_pkg::E8ALU_AND:
    e8alu_pkg::E8ALU_PROBE]} |=> done && flag_mask == 6'h1E && !flags_out[3])
    else $error("logic op mask wrong");
  mul_pair_a: assert property (start && !busy && op inside {[e8alu_pkg::E8ALU_MUL_UU:
    e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU]} |=> !done ##1 done && wr_fixed && wr_pair && flag_mask == 6'h03
    && flags_out[1] == (result == 16'h0000)) else $error("product answer wrong");
  ptr_goto_a: assert property (start && !busy && op == e8alu_pkg::E8ALU_PGOTO
    |-> ##2 done && pc_load && pc_next == {6'h00, $past(z_ptr, 2)}) else $error("pointer jump wrong");
  call_short_a: assert property (start && !busy && !long_pc && op inside
    {e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY, e8alu_pkg::E8ALU_PCALL} |-> ##2 done && push_ret && pc_load)
    else $error("short call timing wrong");
  call_long_a: assert property (start && !busy && long_pc && op inside
    {e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY, e8alu_pkg::E8ALU_PCALL} |=> !done [*2] ##1 done && push_ret)
    else $error("long call timing wrong");
  abs_goto_a: assert property (start && !busy && op == e8alu_pkg::E8ALU_AGOTO
    |=> !done [*2] ##1 done && pc_load && pc_next == $past(jump_arg, 3))
    else $error("absolute jump wrong");
  branch_flags_a: assert property (pc_load |-> done && flag_mask == 6'h00)
    else $error("branch touched flags");
  ones_load_a: assert property (start && !busy && op == e8alu_pkg::E8ALU_ONES
    |=> done && wr_en && result[7:0] == 8'hFF && flag_mask == 6'h00) else $error("ones load wrong");
endmodule

// ### tb/e8alu_status_model.sv
`timescale 1ns/1ps
module e8alu_status_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // answer from the datapath
  input  wire logic       done,
  input  wire logic [5:0] flag_mask,
  input  wire logic [5:0] flags_out,
  // status seen by the datapath
  output logic      [5:0] flags_in
);
  // only masked bits move; unmasked flags keep their history, as a real status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_in <= 6'h00;
    end else if (done) begin
      flags_in <= (flags_in & ~flag_mask) | (flags_out & flag_mask);
    end
  end
endmodule

// ### tb/e8alu_execute_test.sv
`timescale 1ns/1ps
module e8alu_execute_test;
  typedef struct {
    logic [15:0] res;
    logic [15:0] rm;
    logic [5:0]  fm;
    logic [5:0]  fl;
    logic [5:0]  flm;
    logic [21:0] pc;
    logic [21:0] pcm;
    logic        pcl;
    logic        psh;
    int          cyc;
    int          t0;
  } e8alu_exp_t;
  // ************************************************************
  // signals
  // ************************************************************
  logic                 clk = 1'b0;
  logic                 rst_n, start, long_pc, busy, done, wr_en, wr_pair, wr_fixed;
  e8alu_pkg::e8alu_op_t op;
  logic [15:0]          opd_a, z_ptr, result;
  logic [7:0]           opd_b;
  logic [21:0]          pc_cur, jump_arg, pc_next;
  logic [5:0]           flags_in, flag_mask, flags_out;
  logic                 pc_load, push_ret;
  int                   n_errors = 0, tests_run = 0, clk_count = 0, i, k, n;
  logic [31:0]          seed = 32'hb92481dc;
  e8alu_exp_t           exp_q[$];
  e8alu_exp_t           me;
  logic [7:0]           edges[4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};

  always #5 clk = ~clk;
  always @(posedge clk) clk_count <= clk_count + 1;

  e8alu_execute u_e8alu_execute (.clk(clk), .rst_n(rst_n), .start(start), .op(op),
    .opd_a(opd_a), .opd_b(opd_b), .z_ptr(z_ptr), .pc_cur(pc_cur), .jump_arg(jump_arg),
    .long_pc(long_pc), .flags_in(flags_in), .busy(busy), .done(done), .wr_en(wr_en),
    .wr_pair(wr_pair), .wr_fixed(wr_fixed), .result(result), .flag_mask(flag_mask),
    .flags_out(flags_out), .pc_load(pc_load), .pc_next(pc_next), .push_ret(push_ret));
  e8alu_status_model u_e8alu_status_model (.clk(clk), .rst_n(rst_n), .done(done),
    .flag_mask(flag_mask), .flags_out(flags_out), .flags_in(flags_in));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ************************************************************
  // driver: one request, expectation noted before the take edge
  // ************************************************************
  task automatic issue(input e8alu_pkg::e8alu_op_t o, input logic [15:0] a,
                       input logic [7:0] b, input logic lp, input logic refuse);
    e8alu_exp_t  e;
    logic [16:0] s, ab;
    logic [15:0] x, y, p;
    logic        wide;
    int          w;
    op = o; opd_a = a; opd_b = b; long_pc = lp; start = 1'b1;
    z_ptr = 16'($random(seed)); pc_cur = 22'($random(seed)); jump_arg = 22'($random(seed));
    ab = {9'h000, a[7:0]};
    x = (o inside {e8alu_pkg::E8ALU_MUL_UU, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_UU}) ? {8'h00, a[7:0]}
        : {{8{a[7]}}, a[7:0]};
    y = (o inside {e8alu_pkg::E8ALU_MUL_SS, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SS}) ? {{8{b[7]}}, b}
        : {8'h00, b};
    p = x * y;
    s = 17'h00000;
    case (o)
      e8alu_pkg::E8ALU_ADD:   s = ab + b;
      e8alu_pkg::E8ALU_ADC:   s = ab + b + flags_in[0];
      e8alu_pkg::E8ALU_SUB:   s = ab - b;
      e8alu_pkg::E8ALU_SBC:   s = ab - b - flags_in[0];
      e8alu_pkg::E8ALU_WADD:  s = {1'b0, a} + b;
      e8alu_pkg::E8ALU_WSUB:  s = {1'b0, a} - b;
      e8alu_pkg::E8ALU_AND:   s = ab & b;
      e8alu_pkg::E8ALU_OR, e8alu_pkg::E8ALU_SETB: s = ab | b;
      e8alu_pkg::E8ALU_XOR:   s = ab ^ b;
      e8alu_pkg::E8ALU_CLRB:  s = ab & {9'h000, ~b};
      e8alu_pkg::E8ALU_PROBE: s = ab;
      e8alu_pkg::E8ALU_COM:   s = {9'h001, ~a[7:0]};
      e8alu_pkg::E8ALU_NEG:   s = 17'h00000 - ab;
      e8alu_pkg::E8ALU_INC:   s = ab + 17'h00001;
      e8alu_pkg::E8ALU_DEC:   s = ab - 17'h00001;
      e8alu_pkg::E8ALU_ONES:  s = 17'h000FF;
      e8alu_pkg::E8ALU_MUL_UU, e8alu_pkg::E8ALU_MUL_SS, e8alu_pkg::E8ALU_MUL_SU: s = {1'b0, p};
      e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_UU, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SS, e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU: begin
        s = {p, 1'b0};
      end
      default: s = 17'h00000;
    endcase
    wide = o inside {e8alu_pkg::E8ALU_WADD, e8alu_pkg::E8ALU_WSUB} ||
           (o >= e8alu_pkg::E8ALU_MUL_UU && o <= e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU);
    e.res = wide ? s[15:0] : {8'h00, s[7:0]};
    e.rm = o >= e8alu_pkg::E8ALU_RGOTO ? 16'h0000 : wide ? 16'hFFFF : 16'h00FF;
    e.fm = (o <= e8alu_pkg::E8ALU_SBC || o == e8alu_pkg::E8ALU_NEG) ? 6'h3F
         : (o inside {e8alu_pkg::E8ALU_WADD, e8alu_pkg::E8ALU_WSUB, e8alu_pkg::E8ALU_COM}) ? 6'h1F
         : (o <= e8alu_pkg::E8ALU_ZREG) ? 6'h1E : (o == e8alu_pkg::E8ALU_ONES) ? 6'h00
         : (o <= e8alu_pkg::E8ALU_FRACTION_PRODUCT_UNSIGNED_SU) ? 6'h03 : 6'h00;
    e.flm = e.fm == 6'h1E ? 6'h0E : e.fm & 6'h07;
    e.fl = {2'b00, (o == e8alu_pkg::E8ALU_INC && a[7:0] == 8'h7F) ||
           (o == e8alu_pkg::E8ALU_DEC && a[7:0] == 8'h80), wide ? s[15] : s[7],
           wide ? s[15:0] == 16'h0000 : s[7:0] == 8'h00,
           e.fm == 6'h03 ? p[15] : wide ? s[16] : s[8]};
    e.pcl = o >= e8alu_pkg::E8ALU_RGOTO;
    e.psh = o inside {e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY, e8alu_pkg::E8ALU_PCALL};
    e.pcm = !e.pcl ? 22'h000000 : o == e8alu_pkg::E8ALU_PCALL ? 22'h00FFFF : 22'h3FFFFF;
    e.pc = (o inside {e8alu_pkg::E8ALU_RGOTO, e8alu_pkg::E8ALU_RELATIVE_SUBROUTINE_ENTRY}) ? pc_cur + jump_arg + 22'h1
         : o == e8alu_pkg::E8ALU_AGOTO ? jump_arg : {6'h00, z_ptr};
    w = e.psh ? (lp ? 3 : 2) : o == e8alu_pkg::E8ALU_AGOTO ? 3 : (wide || e.pcl) ? 2 : 1;
    e.cyc = w;
    e.t0 = clk_count;
    exp_q.push_back(e);
    @(negedge clk);
    n = 0;
    // a request held while busy must be ignored without trace
    while (busy === 1'b1 && n < 8) begin
      start = refuse && n == 0;
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      n_errors++;
      conclude();
    end
  endtask

  // ************************************************************
  // monitor: oldest note against each answer
  // ************************************************************
  always @(negedge clk) begin
    if (rst_n === 1'b1 && done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected done", 32'h0, 32'h1);
      end else begin
        me = exp_q.pop_front();
        chk("latency", me.cyc, clk_count - me.t0);
        chk("result", me.res & me.rm, result & me.rm);
        chk("flag_mask", me.fm, flag_mask);
        chk("flags", me.fl & me.flm, flags_out & me.flm);
        chk("pc_load", me.pcl, pc_load);
        chk("push_ret", me.psh, push_ret);
        chk("pc_next", me.pc & me.pcm, pc_next & me.pcm);
        chk("wr_en", me.rm != 16'h0000, wr_en);
        chk("wr_pair", me.rm == 16'hFFFF, wr_pair);
        chk("wr_fixed", me.fm == 6'h03, wr_fixed);
      end
    end
  end

  initial begin
    #200us;
    n_errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0; start = 1'b0; op = e8alu_pkg::E8ALU_ADD; opd_a = 16'h0000; opd_b = 8'h00;
    z_ptr = 16'h0000; pc_cur = 22'h000000; jump_arg = 22'h000000; long_pc = 1'b0;
    repeat (12) @(negedge clk);
    chk("reset result", 32'h0, result);
    chk("reset pc_next", 32'h0, pc_next);
    chk("reset busy", 32'h0, busy);
    rst_n = 1'b1;
    @(negedge clk);
    for (k = 0; k <= 17; k++) begin
      for (i = 0; i < 24 && k != 4 && k != 5; i++) begin
        issue(e8alu_pkg::e8alu_op_t'(5'(k)), {8'h00, i < 16 ? edges[i % 4] : 8'($random(seed))},
              i < 16 ? edges[i / 4] : 8'($random(seed)), 1'b0, 1'b0);
      end
    end
    for (i = 0; i < 16; i++) begin
      issue(i[0] ? e8alu_pkg::E8ALU_WSUB : e8alu_pkg::E8ALU_WADD, i < 8 ? {edges[i / 2],
            edges[i % 4]} : 16'($random(seed)), i < 8 ? 8'h01 : 8'($random(seed)), 1'b0, 1'b0);
    end
    for (k = 18; k <= 23; k++) begin
      for (i = 0; i < 20; i++) begin
        issue(e8alu_pkg::e8alu_op_t'(5'(k)), {8'h00, i < 16 ? edges[i % 4] : 8'($random(seed))},
              i < 16 ? edges[i / 4] : 8'($random(seed)), 1'b0, 1'b0);
      end
    end
    for (k = 24; k <= 28; k++) begin
      for (i = 0; i < 6; i++) begin
        issue(e8alu_pkg::e8alu_op_t'(5'(k)), 16'h0000, 8'h00, i[0], k == 25 && i == 0);
      end
    end
    start = 1'b0;
    for (i = 0; i < 20 && exp_q.size() > 0; i++) begin
      @(negedge clk);
    end
    chk("answers outstanding", 32'h0, exp_q.size());
    conclude();
  end
endmodule

bind e8alu_execute e8alu_execute_sva u_e8alu_execute_sva (.clk(clk), .rst_n(rst_n),
  .start(start), .op(op), .z_ptr(z_ptr), .jump_arg(jump_arg), .long_pc(long_pc), .busy(busy),
  .done(done), .wr_en(wr_en), .wr_pair(wr_pair), .wr_fixed(wr_fixed), .result(result),
  .flag_mask(flag_mask), .flags_out(flags_out), .pc_load(pc_load), .pc_next(pc_next),
  .push_ret(push_ret));
